// ### rtl/phy_aux_pkg.sv
// package: register map, field positions, encodings and test clock timing of the aux control block
package phy_aux_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] LINK_IDX = 8'h11;
   localparam logic [7:0] AUX_IDX = 8'h12;
   localparam logic [7:0] TEST_IDX = 8'h1c;
   localparam logic [7:0] LINK_ADDR = 8'(LINK_IDX * 4);
   localparam logic [7:0] AUX_ADDR = 8'(AUX_IDX * 4);
   localparam logic [7:0] TEST_ADDR = 8'(TEST_IDX * 4);

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int AUX_AUTO_MDIX_BIT = 15;
   localparam int AUX_MANUAL_MDIX_BIT = 14;
   localparam int AUX_MACIF_HI = 13;
   localparam int AUX_MACIF_LO = 12;
   localparam int AUX_NONCOMPLIANT_BIT = 9;
   localparam int AUX_INBAND_BIT = 8;
   localparam int AUX_TCLK_EN_BIT = 7;
   localparam int AUX_SYNC_EN_BIT = 6;
   localparam int LINK_XOVER_BIT = 10;
   localparam int LINK_SPEED_HI = 4;
   localparam int LINK_SPEED_LO = 3;
   localparam int LINK_UP_BIT = 2;
   localparam int LINK_DUPLEX_BIT = 1;
   localparam int TEST_MODE_HI = 2;

   // ****************************************************************
   // reset values and test modes
   // ****************************************************************
   localparam logic AUX_INBAND_RST = 1'b0;
   localparam logic AUX_TCLK_EN_RST = 1'b0;
   localparam logic AUX_SYNC_EN_RST = 1'b0;
   localparam logic [2:0] TEST_MODE_RST = 3'h0;
   localparam logic [2:0] TEST_MODE_OFF = 3'h0;
   localparam logic [2:0] TEST_MODE_1 = 3'h1;
   localparam logic [2:0] TEST_MODE_4 = 3'h4;

   // ****************************************************************
   // test clock timing, in mclk cycles
   // ****************************************************************
   localparam int TCLK_PERIOD_CYCLES = 2;
   localparam int SYNC_DIV_MODE1 = 4;
   localparam int SYNC_DIV_MODE4 = 6;
   localparam logic [3:0] SYNC_HALF_MODE1 = 4'(SYNC_DIV_MODE1 * TCLK_PERIOD_CYCLES / 2);
   localparam logic [3:0] SYNC_HALF_MODE4 = 4'(SYNC_DIV_MODE4 * TCLK_PERIOD_CYCLES / 2);

   // mac interface selection as driven out
   typedef enum logic [1:0] {
      MACIF_GMII = 2'b00,
      MACIF_RGMII_B = 2'b10,
      MACIF_RGMII_A = 2'b11
   } macif_t;

   // bus transfer phase
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bus_state_t;
endpackage

// ### rtl/phy_aux_control_register.sv
// auxiliary control register bank of a tri-speed phy, with ahb-lite register access
//
// Behaviour
// - With automatic crossover and auto-negotiation on, the pair mapping follows the detected swap and bit 14 is ignored.
// - With auto-negotiation off, the automatic field is ignored and bit 14 applies.
// - In manual operation bit 14 at 1 swaps channels A and B, at 0 keeps them straight.
// - Bits 13:12 pick the mac interface: 11 first rgmii variant, 10 second, 01 and 00 gmii.
// - Bit 9 at 1 admits non-compliant gigabit partners as well, at 0 compliant ones only.
// - Bits 11:10 are reserved, read as zero and ignore whatever is written.
// - In-band status puts link, speed and duplex onto the receive nibble between frames.
// - In-band status has no effect while bit 13 is zero, that is with gmii selected.
// - The test transmit clock is driven in test modes only when bit 7 is set.
// - Bit 6 gates the test sync clock and test trigger outputs in test modes.
// - Sync clock and trigger appear only in test modes 1 and 4.
// - The sync clock is the test transmit clock divided by 4 in mode 1 and by 6 in mode 4.
// - The link status crossover bit reports the mapping in use, 1 crossed and 0 straight.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module phy_aux_control_register
   import phy_aux_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic strapAutoMdix,
   input wire logic strapManualMdix,
   input wire logic [1:0] strapMacIf,
   input wire logic strapNonCompliant,
   input wire logic autonegOn,
   input wire logic swapDetected,
   input wire logic linkUp,
   input wire logic [1:0] linkSpeed,
   input wire logic fullDuplex,
   input wire logic rxFrameActive,
   input wire logic [3:0] rxdIn,
   output logic [3:0] rxdOut,
   output logic mdixCross,
   output macif_t macIfSel,
   output logic nonCompliantEn,
   output logic testTxClkOut,
   output logic testSyncClkOut,
   output logic testTriggerOut
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   bus_state_t busState_reg;
   logic [7:0] addr_reg;
   logic acceptAddr;
   logic [31:0] readData;
   logic strapDone_reg;
   logic autoMdix_reg;
   logic manualMdix_reg;
   logic [1:0] macIf_reg;
   logic nonCompliant_reg;
   logic inBand_reg;
   logic tclkEn_reg;
   logic syncEn_reg;
   logic [2:0] testMode_reg;
   logic xoverNext;
   logic inTestMode;
   logic syncActive;
   logic [3:0] syncHalf;
   logic [3:0] syncCnt_reg;
   logic writeAux;
   logic writeTest;

   // ****************************************************************
   // ahb-lite slave
   // ****************************************************************
   // only nonseq and seq start a transfer; idle and busy pass untouched
   assign acceptAddr = hsel && hready && htrans[1];
   assign writeAux = (busState_reg == BUS_WRITE) && (addr_reg == AUX_ADDR);
   assign writeTest = (busState_reg == BUS_WRITE) && (addr_reg == TEST_ADDR);

   // transfer phase tracking; reads take one wait state so hrdata comes from a flop
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busState_reg <= BUS_IDLE;
         addr_reg <= 8'h00;
         hreadyout <= 1'b1;
      end else if (ce) begin
         if (busState_reg == BUS_READ) begin
            busState_reg <= BUS_IDLE;
            hreadyout <= 1'b1;
         end else if (acceptAddr) begin
            addr_reg <= haddr[7:0];
            busState_reg <= hwrite ? BUS_WRITE : BUS_READ;
            hreadyout <= hwrite;
         end else begin
            busState_reg <= BUS_IDLE;
         end
      end
   end

   // responses are always okay; unmapped reads give zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hresp <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0;
      end
   end

   // read mux; reserved and unused bits return zero
   always_comb begin
      readData = 32'h0000_0000;
      unique case (addr_reg)
         AUX_ADDR: begin
            readData[AUX_AUTO_MDIX_BIT] = autoMdix_reg;
            readData[AUX_MANUAL_MDIX_BIT] = manualMdix_reg;
            readData[AUX_MACIF_HI:AUX_MACIF_LO] = macIf_reg;
            readData[AUX_NONCOMPLIANT_BIT] = nonCompliant_reg;
            readData[AUX_INBAND_BIT] = inBand_reg;
            readData[AUX_TCLK_EN_BIT] = tclkEn_reg;
            readData[AUX_SYNC_EN_BIT] = syncEn_reg;
         end
         LINK_ADDR: begin
            readData[LINK_XOVER_BIT] = mdixCross;
            readData[LINK_SPEED_HI:LINK_SPEED_LO] = linkSpeed;
            readData[LINK_UP_BIT] = linkUp;
            readData[LINK_DUPLEX_BIT] = fullDuplex;
         end
         TEST_ADDR: begin
            readData[TEST_MODE_HI:0] = testMode_reg;
         end
         default: begin
            readData = 32'h0000_0000;
         end
      endcase
   end

   // read data captured in the wait cycle, after any write just committed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && busState_reg == BUS_READ) begin
         hrdata <= readData;
      end
   end

   // ****************************************************************
   // control fields
   // ****************************************************************
   // straps caught on the first enabled edge after release
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         strapDone_reg <= 1'b0;
         autoMdix_reg <= 1'b0;
         manualMdix_reg <= 1'b0;
         macIf_reg <= 2'b00;
         nonCompliant_reg <= 1'b0;
      end else if (ce) begin
         if (!strapDone_reg) begin
            strapDone_reg <= 1'b1;
            autoMdix_reg <= strapAutoMdix;
            manualMdix_reg <= strapManualMdix;
            macIf_reg <= strapMacIf;
            nonCompliant_reg <= strapNonCompliant;
         end else if (writeAux) begin
            autoMdix_reg <= hwdata[AUX_AUTO_MDIX_BIT];
            manualMdix_reg <= hwdata[AUX_MANUAL_MDIX_BIT];
            macIf_reg <= hwdata[AUX_MACIF_HI:AUX_MACIF_LO];
            nonCompliant_reg <= hwdata[AUX_NONCOMPLIANT_BIT];
         end
      end
   end

   // reserved bits have no storage; writes there are dropped
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         inBand_reg <= AUX_INBAND_RST;
         tclkEn_reg <= AUX_TCLK_EN_RST;
         syncEn_reg <= AUX_SYNC_EN_RST;
      end else if (ce && writeAux) begin
         inBand_reg <= hwdata[AUX_INBAND_BIT];
         tclkEn_reg <= hwdata[AUX_TCLK_EN_BIT];
         syncEn_reg <= hwdata[AUX_SYNC_EN_BIT];
      end
   end

   // test mode select, kept beside the aux bank
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         testMode_reg <= TEST_MODE_RST;
      end else if (ce && writeTest) begin
         testMode_reg <= hwdata[TEST_MODE_HI:0];
      end
   end

   // ****************************************************************
   // crossover, interface and compliance outputs
   // ****************************************************************
   // auto mode trusts the detector
   // without autoneg the manual bit rules
   always_comb begin
      if (autonegOn && autoMdix_reg) begin
         xoverNext = swapDetected;
      end else begin
         xoverNext = manualMdix_reg;
      end
   end

   // 1 swaps pairs a and b
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mdixCross <= 1'b0;
         nonCompliantEn <= 1'b0;
      end else if (ce) begin
         mdixCross <= xoverNext;
         nonCompliantEn <= nonCompliant_reg;
      end
   end

   // interface decode; 01 folds into gmii
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         macIfSel <= MACIF_GMII;
      end else if (ce) begin
         unique case (macIf_reg)
            2'b11: macIfSel <= MACIF_RGMII_A;
            2'b10: macIfSel <= MACIF_RGMII_B;
            2'b01: macIfSel <= MACIF_GMII;
            2'b00: macIfSel <= MACIF_GMII;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rxdOut <= 4'h0;
      end else if (ce) begin
         if (inBand_reg && macIf_reg[1] && !rxFrameActive) begin
            rxdOut <= {fullDuplex, linkSpeed, linkUp};
         end else begin
            rxdOut <= rxdIn;
         end
      end
   end

   // ****************************************************************
   // gigabit test mode clocks
   // ****************************************************************
   assign inTestMode = (testMode_reg != TEST_MODE_OFF);
   // only modes 1 and 4 carry sync and trigger
   assign syncActive = syncEn_reg && (testMode_reg == TEST_MODE_1 || testMode_reg == TEST_MODE_4);
   assign syncHalf = (testMode_reg == TEST_MODE_4) ? SYNC_HALF_MODE4 : SYNC_HALF_MODE1;

   // tx test clock toggles only when enabled in a test mode
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         testTxClkOut <= 1'b0;
      end else if (ce) begin
         testTxClkOut <= (tclkEn_reg && inTestMode) ? !testTxClkOut : 1'b0;
      end
   end

   // sync and trigger held low unless enabled
   // trigger is one cycle at each sync rise, simplest edge a scope can key on
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         syncCnt_reg <= 4'h0;
         testSyncClkOut <= 1'b0;
         testTriggerOut <= 1'b0;
      end else if (ce) begin
         if (!syncActive) begin
            syncCnt_reg <= 4'h0;
            testSyncClkOut <= 1'b0;
            testTriggerOut <= 1'b0;
         end else if (syncCnt_reg >= syncHalf - 4'h1) begin
            syncCnt_reg <= 4'h0;
            testSyncClkOut <= !testSyncClkOut;
            testTriggerOut <= !testSyncClkOut;
         end else begin
            syncCnt_reg <= syncCnt_reg + 4'h1;
            testTriggerOut <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_xover_auto: assert property (
      ce && $past(ce) && $past(autonegOn && autoMdix_reg) |-> mdixCross == $past(swapDetected))
      else $error("crossover ignores detector");
   a_xover_manual: assert property (
      ce && $past(ce) && $past(!autonegOn || !autoMdix_reg)
      |-> mdixCross == $past(manualMdix_reg)) else $error("manual crossover lost");
   a_macif_decode: assert property (
      ce && $past(ce) |-> macIfSel == (($past(macIf_reg) == 2'b11) ? MACIF_RGMII_A :
      ($past(macIf_reg) == 2'b10) ? MACIF_RGMII_B : MACIF_GMII))
      else $error("mac interface decode wrong");
   a_nc_follows: assert property (
      ce && $past(ce) |-> nonCompliantEn == $past(nonCompliant_reg))
      else $error("non-compliant enable wrong");
   a_rsvd_zero: assert property (
      ce && busState_reg == BUS_READ && addr_reg == AUX_ADDR |=> hrdata[11:10] == 2'b00)
      else $error("reserved bits not zero");
   a_inband_gap: assert property (
      ce && $past(ce) && $past(inBand_reg && macIf_reg[1] && !rxFrameActive)
      |-> rxdOut == $past({fullDuplex, linkSpeed, linkUp})) else $error("no in-band status");
   a_inband_gmii: assert property (
      ce && $past(ce) && $past(!macIf_reg[1]) |-> rxdOut == $past(rxdIn))
      else $error("in-band status on gmii");
   a_tclk_gate: assert property (
      ce && $past(ce) && $past(!tclkEn_reg || !inTestMode) |-> !testTxClkOut)
      else $error("test clock without enable");
   a_sync_gate: assert property (
      ce && $past(ce) && $past(!syncActive) |-> !testSyncClkOut && !testTriggerOut)
      else $error("sync or trigger ungated");
   // leaving modes 1 and 4 or clearing the sync enable cuts the running half period, so such attempts are dropped
   a_sync_div1: assert property (disable iff (!rst_b || !ce || !syncActive)
      $rose(testSyncClkOut) && testMode_reg == TEST_MODE_1
      |-> testSyncClkOut[*4] ##1 !testSyncClkOut) else $error("mode 1 divide wrong");
   a_sync_div4: assert property (disable iff (!rst_b || !ce || !syncActive)
      $rose(testSyncClkOut) && testMode_reg == TEST_MODE_4
      |-> testSyncClkOut[*6] ##1 !testSyncClkOut) else $error("mode 4 divide wrong");
   a_strap_load: assert property (
      $rose(strapDone_reg) |-> autoMdix_reg == $past(strapAutoMdix)
      && manualMdix_reg == $past(strapManualMdix) && macIf_reg == $past(strapMacIf)
      && nonCompliant_reg == $past(strapNonCompliant)
      && !inBand_reg && !tclkEn_reg && !syncEn_reg) else $error("strap load wrong");
   a_xover_status: assert property (
      ce && busState_reg == BUS_READ && addr_reg == LINK_ADDR
      |=> hrdata[LINK_XOVER_BIT] == $past(mdixCross)) else $error("crossover status wrong");

   c_aux_write: cover property (ce && writeAux);
   c_link_read: cover property (ce && busState_reg == BUS_READ && addr_reg == LINK_ADDR);
   c_sync_mode4: cover property ($rose(testSyncClkOut) && testMode_reg == TEST_MODE_4);
   c_sync_mode1: cover property ($rose(testSyncClkOut) && testMode_reg == TEST_MODE_1);
   c_inband_gap: cover property (ce && inBand_reg && macIf_reg[1] && !rxFrameActive);
endmodule
`default_nettype wire

// ### tb/mac_rx_model.sv
// receive datapath stand-in feeding frames and gaps to the in-band logic
`timescale 1ns/1ns
`default_nettype none
module mac_rx_model (
   input wire logic mclk,
   input wire logic rst_b,
   output logic rxFrameActive = 1'b0,
   output logic [3:0] rxdIn = 4'h0
);
   logic [3:0] left = 4'h3;

   // frames and gaps of random length
   // gap data inverts each cycle, so a stale nibble never passes for status
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rxFrameActive <= 1'b0;
         rxdIn <= 4'h0;
         left <= 4'h3;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
         rxdIn <= rxFrameActive ? 4'($urandom) : ~rxdIn;
      end else begin
         rxFrameActive <= ~rxFrameActive;
         left <= 4'(2 + $urandom % 7);
         rxdIn <= 4'($urandom);
      end
   end
endmodule
`default_nettype wire

// ### tb/phy_aux_control_register_tb.sv
// self-checking bench of the aux control register bank
`timescale 1ns/1ns
`default_nettype none
module phy_aux_control_register_tb import phy_aux_pkg::*;;
   logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0, sMac = 2'h0, linkSpeed = 2'h0, en;
   logic [2:0] hsize = 3'h2, m;
   logic hreadyout, hresp, sAuto = 1'b0, sMan = 1'b0, sNc = 1'b0;
   logic autonegOn = 1'b0, swapDetected = 1'b0, linkUp = 1'b0, fullDuplex = 1'b0;
   logic rxFrameActive, mdixCross, nonCompliantEn, tclk, sync, trig, prevT, prevS;
   logic [3:0] rxdIn, rxdOut, rxPrev = 4'h0;
   logic [15:0] v, auxVal = 16'h0;
   logic rxChk = 1'b0;
   macif_t macIfSel;
   int mismatches = 0, nTests = 0, nT, nR, nTr, f1, f2, bad;

   initial forever #20 mclk = ~mclk;

   phy_aux_control_register dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .strapAutoMdix(sAuto), .strapManualMdix(sMan), .strapMacIf(sMac),
      .strapNonCompliant(sNc), .autonegOn(autonegOn), .swapDetected(swapDetected),
      .linkUp(linkUp), .linkSpeed(linkSpeed), .fullDuplex(fullDuplex),
      .rxFrameActive(rxFrameActive), .rxdIn(rxdIn), .rxdOut(rxdOut), .mdixCross(mdixCross),
      .macIfSel(macIfSel), .nonCompliantEn(nonCompliantEn), .testTxClkOut(tclk),
      .testSyncClkOut(sync), .testTriggerOut(trig));
   mac_rx_model partner (.mclk(mclk), .rst_b(rst_b), .rxFrameActive(rxFrameActive),
      .rxdIn(rxdIn));

   // ****************************************************************
   // expectations and helpers
   // ****************************************************************
   function automatic logic xover(input logic an, input logic b15, input logic b14,
         input logic sw);
      return (an && b15) ? sw : b14;
   endfunction

   function automatic logic [1:0] macExp(input logic [1:0] f);
      return f[1] ? f : 2'b00;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      nTests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task stop_test();
      $display("checks %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one ahb-lite single transfer; waits on hready, read data taken at the last edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= 32'(a);
      hwrite <= wr;
      // no wait count assumed; only the watchdog ends a stuck transfer
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk(32'(hresp), 32'h0, "response not okay");
   endtask

   // straps picked at random, reset held 6 cycles, first access driven at the 3rd edge after
   task automatic resetTest();
      @(posedge mclk);
      rst_b <= 1'b0;
      {sAuto, sMan, sMac, sNc, autonegOn, swapDetected} <= 7'($urandom);
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      bus(1'b0, AUX_ADDR, 32'h0);
      chk(q, {16'h0, sAuto, sMan, sMac, 2'b00, sNc, 9'h0}, "aux reset value");
      chk(32'(macIfSel), 32'(macExp(sMac)), "strap mac select");
      chk(32'(nonCompliantEn), 32'(sNc), "strap compliance");
      chk(32'(mdixCross), 32'(xover(autonegOn, sAuto, sMan, swapDetected)), "strap xover");
      bus(1'b0, TEST_ADDR, 32'h0);
      chk(q, 32'(TEST_MODE_RST), "test mode reset");
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   // in-band monitor: rxdOut follows the previous cycle's inputs
   always @(posedge mclk) begin
      if (rxChk)
         chk(32'(rxdOut), 32'(rxPrev), "rx nibble");
      rxPrev = (auxVal[8] && auxVal[13] && !rxFrameActive) ?
         {fullDuplex, linkSpeed, linkUp} : rxdIn;
   end

   initial begin
      #(40 * 5000);
      mismatches++;
      stop_test();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h7358));
      resetTest();
      // every crossover combination, each mac code, reserved bits written as ones
      for (int i = 0; i < 16; i++) begin
         v = 16'($urandom) | 16'h0c00;
         {v[15], v[14], v[13:12]} = {i[1], i[2], i[1:0]};
         autonegOn <= i[0];
         swapDetected <= i[3];
         {fullDuplex, linkSpeed, linkUp} <= 4'($urandom);
         bus(1'b1, AUX_ADDR, {16'hffff, v});
         repeat (2) @(posedge mclk);
         chk(32'(mdixCross), 32'(xover(i[0], i[1], i[2], i[3])), "mdix in use");
         chk(32'(macIfSel), 32'(macExp(v[13:12])), "mac select");
         chk(32'(nonCompliantEn), 32'(v[9]), "compliance");
         bus(1'b0, AUX_ADDR, 32'h0);
         chk(q, {16'h0, v & 16'hf3c0}, "aux readback");
         // software reads the status bit for the real mapping
         bus(1'b0, LINK_ADDR, 32'h0);
         chk(32'(q[10]), 32'(xover(i[0], i[1], i[2], i[3])), "xover status");
         chk(32'(q[4:1]), 32'({linkSpeed, linkUp, fullDuplex}), "link status");
      end
      // clock enable low must freeze the crossover output while the detector moves
      ce <= 1'b0;
      swapDetected <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'(mdixCross), 32'(xover(1'b1, 1'b1, 1'b1, 1'b1)), "frozen by ce");
      ce <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'(mdixCross), 32'(xover(1'b1, 1'b1, 1'b1, 1'b0)), "ce released");
      $display("test crossover done");
      resetTest();
      // in-band on and off, rgmii and gmii, with status changing every cycle
      for (int j = 0; j < 4; j++) begin
         // bit 13 picks rgmii or gmii (bit 12 set), bit 8 the in-band enable
         v = {2'b00, j[0], 1'b1, 3'h0, j[1], 8'h0};
         bus(1'b1, AUX_ADDR, 32'(v));
         @(posedge mclk);
         auxVal <= v;
         @(posedge mclk);
         rxChk <= 1'b1;
         repeat (40) begin
            @(posedge mclk);
            {fullDuplex, linkSpeed, linkUp} <= 4'($urandom);
         end
         rxChk <= 1'b0;
      end
      $display("test in-band done");
      // every test mode, enables taken from the low index bits, then both set
      for (int k = 0; k < 16; k++) begin
         m = k[2:0];
         // mode 1 meets enables 10 and 11, mode 4 meets 00 and 11, the modes without sync all four pairs between them but only 11 in modes 3 and 7
         en = k[3] ? 2'b11 : {k[0], k[1]};
         bus(1'b1, AUX_ADDR, {24'h0, en, 6'h0});
         bus(1'b1, TEST_ADDR, 32'(m));
         repeat (3) @(posedge mclk);
         {nT, nR, nTr, f1, f2, bad} = {32'd0, 32'd0, 32'd0, -32'd1, -32'd1, 32'd0};
         {prevT, prevS} = {tclk, sync};
         for (int c = 0; c < 40; c++) begin
            @(posedge mclk);
            nT += (tclk !== prevT);
            nTr += (trig === 1'b1);
            bad += (trig !== (sync && !prevS));
            if (sync && !prevS) begin
               nR++;
               if (f1 < 0) f1 = c;
               else if (f2 < 0) f2 = c;
            end
            {prevT, prevS} = {tclk, sync};
         end
         chk(32'(nT), (en[1] && m != TEST_MODE_OFF) ? 32'd40 : 32'd0, "tx test clock");
         chk(32'(bad), 32'd0, "trigger at sync rise");
         chk(32'(nTr), 32'(nR), "trigger count");
         if (en[0] && (m == TEST_MODE_1 || m == TEST_MODE_4))
            chk(32'(f2 - f1), 32'((m == TEST_MODE_1 ? SYNC_DIV_MODE1 : SYNC_DIV_MODE4)
               * TCLK_PERIOD_CYCLES), "sync period");
         else
            chk(32'(nR), 32'd0, "sync off");
      end
      $display("test clocks done");
      stop_test();
   end
endmodule
`default_nettype wire
